// ===== shreg_defs.vh
// constants for the dual recirculating shift register
`ifndef SHREG_DEFS_VH
`define SHREG_DEFS_VH
`define SHREG_STAGES      128
`define SHREG_FIFO_DEPTH  32
`define SHREG_FIFO_AW     5
`define SHREG_FIFO_WIDTH  1
`define SHREG_SEL_SERIAL  1'b1
`define SHREG_SEL_RECIRC  1'b0
`define SHREG_OUT_RESET   1'b0
`define SHREG_MAX_LINK_HZ 1000000
`define SHREG_CORE_HZ     200000000
`endif

// ===== dual_recirculating_shift_register.v
// dual 128-stage recirculating shift register with pin-clocked sections
//
// Functional notes
// [R1] two independent 128-stage sections, own clocks
// [R2] select one: serial input, zero: recirculation input
// [R3] selected bit sampled while clock low
// [R4] each rising edge moves every stage forward
// [R5] output is final stage, 128 edges late
// [R6] output changes only after a rising edge
// [R7] clock held high keeps contents forever
// [R8] partner may tie recirculation input to output
// [R9] partner clocks sections at most 1 MHz
// [R10] stage contents have no reset or clear
// [R11] partner holds inputs steady around edges
`timescale 1ns/1ps
`include "shreg_defs.vh"

// small synchronous fifo with valid/ready on both sides
module shreg_fifo
#(
   parameter WIDTH = `SHREG_FIFO_WIDTH,
   parameter DEPTH = `SHREG_FIFO_DEPTH,
   parameter AW    = `SHREG_FIFO_AW
)
(
   input  wire             i_core_clk,
   input  wire             i_rst_n,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // word store
   reg [AW-1:0]    wr_ptr;          // next write slot
   reg [AW-1:0]    rd_ptr;          // next read slot
   reg [AW:0]      count;           // words held
   wire            push;
   wire            pop;

   assign o_in_ready  = (count != DEPTH[AW:0]);
   assign o_out_valid = (count != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // storage itself is not reset, only the pointers and count
   always @(posedge i_core_clk)
   begin
      if (push)
         mem[wr_ptr] <= i_in_data;
   end

   // pointer and fill bookkeeping
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end
endmodule

// one shift section, clocked from its own pin via edge detection
module shreg_section
(
   input  wire i_core_clk,
   input  wire i_rst_n,
   input  wire i_sec_clk,
   input  wire i_serial_in,
   input  wire i_recirc_in,
   input  wire i_recirc_select,
   output reg  o_data_out,
   output wire o_overrun
);
   reg  [2:0] clk_sync;      // two sync stages plus edge history
   reg  [1:0] ser_sync;      // serial input synchroniser
   reg  [1:0] recirc_sync;   // recirculation input synchroniser
   reg  [1:0] sel_sync;      // select synchroniser
   reg        held_bit;      // bit accepted while clock low
   reg        shift_busy;    // spaces pops one per two cycles
   reg  [`SHREG_STAGES-1:0] stages; // stage 1 is bit 0
   reg        overrun;       // sticky: edge arrived with fifo full
   wire       rise;
   wire       q_ready;
   wire       q_valid;
   wire       q_bit;
   wire       pop;

   // pins cross into the core clock through two flops each
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         clk_sync <= 3'h7;
         ser_sync <= 2'h0;
         recirc_sync <= 2'h0;
         sel_sync <= 2'h0;
      end
      else
      begin
         clk_sync <= {clk_sync[1:0], i_sec_clk};
         ser_sync <= {ser_sync[0], i_serial_in};
         recirc_sync <= {recirc_sync[0], i_recirc_in};
         sel_sync <= {sel_sync[0], i_recirc_select};
      end
   end

   // reset value high so a held-high clock at release is no edge
   assign rise = clk_sync[1] & ~clk_sync[2];  // [R1]

   // track the selected input only while the section clock is low
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         held_bit <= 1'b0;
      else if (!clk_sync[1])                    // [R3]
      begin
         if (sel_sync[1] == `SHREG_SEL_SERIAL)
            held_bit <= ser_sync[1];            // [R2]
         else
            held_bit <= recirc_sync[1];         // [R2]
      end
   end

   // captured bits queue up; a full queue drops the edge and flags it
   shreg_fifo #(
      .WIDTH (`SHREG_FIFO_WIDTH),
      .DEPTH (`SHREG_FIFO_DEPTH),
      .AW    (`SHREG_FIFO_AW)
   ) u_queue (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (rise),                      // [R3]
      .o_in_ready  (q_ready),
      .i_in_data   (held_bit),
      .o_out_valid (q_valid),
      .i_out_ready (~shift_busy),
      .o_out_data  (q_bit)
   );

   assign pop       = q_valid & ~shift_busy;
   assign o_overrun = overrun;

   // shift engine: one queued edge moves the whole chain
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         shift_busy <= 1'b0;
         overrun    <= 1'b0;
      end
      else
      begin
         shift_busy <= pop;
         if (rise & ~q_ready)
            overrun <= 1'b1;
      end
   end

   // stages have no reset; contents unknown until 128 edges   [R10]
   // nothing moves without an edge, so data stays static      [R7]
   always @(posedge i_core_clk)
   begin
      if (pop)
         stages <= {stages[`SHREG_STAGES-2:0], q_bit};  // [R4]
   end

   // buffered copy of the final stage taken as it shifts out, so the
   // pin shows the bit entered exactly 128 rises earlier   [R5]
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_data_out <= `SHREG_OUT_RESET;
      else if (pop)                              // [R6]
         o_data_out <= stages[`SHREG_STAGES-1];   // [R5]
   end
endmodule

// top: two sections sharing only the core clock and reset
module dual_recirculating_shift_register
(
   input  wire i_core_clk,
   input  wire i_rst_n,
   input  wire i_sec_a_clk,
   input  wire i_sec_a_serial_in,
   input  wire i_sec_a_recirc_in,
   input  wire i_sec_a_recirc_select,
   output wire o_sec_a_out,
   output wire o_sec_a_overrun,
   input  wire i_sec_b_clk,
   input  wire i_sec_b_serial_in,
   input  wire i_sec_b_recirc_in,
   input  wire i_sec_b_recirc_select,
   output wire o_sec_b_out,
   output wire o_sec_b_overrun
);
   // section a shares only i_core_clk and i_rst_n with section b   [R1]
   shreg_section u_sec_a (
      .i_core_clk      (i_core_clk),
      .i_rst_n         (i_rst_n),
      .i_sec_clk       (i_sec_a_clk),
      .i_serial_in     (i_sec_a_serial_in),
      .i_recirc_in     (i_sec_a_recirc_in),
      .i_recirc_select (i_sec_a_recirc_select),
      .o_data_out      (o_sec_a_out),
      .o_overrun       (o_sec_a_overrun)
   );

   shreg_section u_sec_b (
      .i_core_clk      (i_core_clk),
      .i_rst_n         (i_rst_n),
      .i_sec_clk       (i_sec_b_clk),
      .i_serial_in     (i_sec_b_serial_in),
      .i_recirc_in     (i_sec_b_recirc_in),
      .i_recirc_select (i_sec_b_recirc_select),
      .o_data_out      (o_sec_b_out),
      .o_overrun       (o_sec_b_overrun)
   );
endmodule

// ===== shreg_drv.sv
// far-side driving logic for one shift section
`timescale 1ns/1ps
module shreg_drv
(
   input  logic i_core_clk,
   input  logic i_out,
   output logic o_clk,
   output logic o_ser,
   output logic o_sel,
   output logic o_recirc
);
   // recirculation input wired straight back to the output
   assign o_recirc = i_out;
   // clock idles high so the contents are kept
   initial
   begin
      o_clk = 1'b1;
      o_ser = 1'b1;
      o_sel = 1'b1;
   end
   // one shift: 500 ns low with data set, 500 ns high
   task automatic shift(input logic sel, input logic d);
      @(negedge i_core_clk);
      o_clk = 1'b0;
      o_sel = sel;
      o_ser = d;
      repeat (100) @(negedge i_core_clk);
      o_clk = 1'b1;
      repeat (100) @(negedge i_core_clk);
   endtask
endmodule

// ===== shreg_asserts.sv
// port checker for the dual recirculating shift register
`timescale 1ns/1ps
module shreg_asserts
(
   input logic i_core_clk,
   input logic i_rst_n,
   input logic i_sec_a_clk,
   input logic i_sec_b_clk,
   input logic o_sec_a_out,
   input logic o_sec_b_out,
   input logic o_sec_a_overrun,
   input logic o_sec_b_overrun
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // a move needs a pin rise; 12 cycles back the pin was low
   chk_a_out_quiet: assert property ($changed(o_sec_a_out) |->
      !$past(i_sec_a_clk, 12)) else $error("a out moved");
   chk_b_out_quiet: assert property ($changed(o_sec_b_out) |->
      !$past(i_sec_b_clk, 12)) else $error("b out moved");
   chk_a_hold_keep: assert property (i_sec_a_clk [*8] |=>
      $stable(o_sec_a_out)) else $error("a out not held");
   chk_b_hold_keep: assert property (i_sec_b_clk [*8] |=>
      $stable(o_sec_b_out)) else $error("b out not held");
   chk_a_no_drop: assert property (!o_sec_a_overrun)
      else $error("a rise dropped");
   chk_b_no_drop: assert property (!o_sec_b_overrun)
      else $error("b rise dropped");
   // synchronising takes cycles, so no instant response
   chk_a_not_early: assert property ($rose(i_sec_a_clk) |=>
      $stable(o_sec_a_out) [*2]) else $error("a out early");
   chk_rst_out_low: assert property (disable iff (1'b0)
      !i_rst_n |=> !o_sec_a_out && !o_sec_b_out)
      else $error("out not low in reset");
endmodule
bind dual_recirculating_shift_register shreg_asserts u_chk (.*);

// ===== dual_recirculating_shift_register_tb.sv
// self-checking bench for the dual recirculating shift register
`timescale 1ns/1ps
module dual_recirculating_shift_register_tb;
   localparam logic [127:0] PAT = 128'h0123456789ABCDEF_F0E1D2C3B4A59687;
   logic i_core_clk, i_rst_n;
   logic a_clk, a_ser, a_sel, a_recirc, a_out, a_ovr;
   logic b_clk, b_ser, b_sel, b_recirc, b_out, b_ovr;
   int   n_mismatch, check_count;
   dual_recirculating_shift_register u_dut (.i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n), .i_sec_a_clk(a_clk), .i_sec_a_serial_in(a_ser),
      .i_sec_a_recirc_in(a_recirc), .i_sec_a_recirc_select(a_sel),
      .o_sec_a_out(a_out), .o_sec_a_overrun(a_ovr), .i_sec_b_clk(b_clk),
      .i_sec_b_serial_in(b_ser), .i_sec_b_recirc_in(b_recirc),
      .i_sec_b_recirc_select(b_sel), .o_sec_b_out(b_out),
      .o_sec_b_overrun(b_ovr));
   shreg_drv u_drv_a (.i_core_clk(i_core_clk), .i_out(a_out),
      .o_clk(a_clk), .o_ser(a_ser), .o_sel(a_sel), .o_recirc(a_recirc));
   shreg_drv u_drv_b (.i_core_clk(i_core_clk), .i_out(b_out),
      .o_clk(b_clk), .o_ser(b_ser), .o_sel(b_sel), .o_recirc(b_recirc));
   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   task automatic check(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // 130 bits in serially, then 140 recirculated with the serial
   // line showing the inverse so that it must be ignored
   task automatic t_stream(input bit s, input logic [127:0] p);
      logic h[$];
      logic e, sel, d;
      for (int k = 1; k <= 270; k++)
      begin
         sel = (k <= 130);
         e = (k > 129) ? h[k-130] : 1'b0;
         d = sel ? p[k%128] : ~e;
         h.push_back(sel ? d : e);
         if (s) u_drv_b.shift(sel, d);
         else u_drv_a.shift(sel, d);
         if (k > 128) check("out", h[k-129], s ? b_out : a_out);
      end
      repeat (2000) @(negedge i_core_clk);
      check("held", h[141], s ? b_out : a_out);
      check("overrun", 1'b0, s ? b_ovr : a_ovr);
      $display("t_stream section %0d done", s);
   endtask
   initial
   begin
      i_rst_n = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      repeat (10) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      fork
         t_stream(1'b0, PAT);
         t_stream(1'b1, ~PAT);
      join
      tally_and_finish;
   end
   // run needs about 56k cycles
   initial
   begin
      #400000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule
